// file: verilog/msr_mixed_status.sv
// Mixed status register: clock switch, FIFO empty, guard time, presence, tx/rx flag
`timescale 1ns/1ps
module msr_mixed_status (
  input  wire logic                  i_clock,
  input  wire logic                  i_rstn,
  input  wire logic                  i_uart_reset_release,
  input  wire msr_pkg::msr_bus_t     i_bus,
  input  wire msr_pkg::msr_uart_evt_t i_evt,
  input  wire logic                  i_clk_switch_to_int_done,
  input  wire logic                  i_clk_switch_to_xtal_done,
  input  wire logic                  i_fifo_count_zero,
  input  wire logic                  i_protocol_t1,
  input  wire logic                  i_etu_tick,
  input  wire logic                  i_io_start_bit,
  input  wire logic                  i_card_presence_pin,
  input  wire logic                  i_tx_rx_flag_irq_mask,
  output logic [7:0]                 o_mixed_status,
  output logic                       o_host_irq_n
);

  logic       presence_meta_reg;
  logic       presence_sync_reg;
  logic       clock_switch_done_reg;
  logic       fifo_empty_reg;
  logic       tx_empty_rx_full_reg;
  logic       tx_mode_reg;
  logic [1:0] clear_delay_reg;
  logic       clear_pending_reg;
  logic       guard_done;
  logic       holding_access;
  logic       mode_to_tx;
  logic       mode_to_rx;
  logic       set_event;
  logic       clear_event;
  logic [7:0] status_next;

  // Presence contact is an asynchronous pin
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      presence_meta_reg <= 1'b0;
      presence_sync_reg <= 1'b0;
    end
    else
    begin
      presence_meta_reg <= i_card_presence_pin;
      presence_sync_reg <= presence_meta_reg;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn || !i_uart_reset_release)
      clock_switch_done_reg <= msr_pkg::CLOCK_SWITCH_DONE_RESET;
    else if (i_clk_switch_to_int_done)
      clock_switch_done_reg <= 1'b1;
    else if (i_clk_switch_to_xtal_done)
      clock_switch_done_reg <= 1'b0;
  end

  // Registered copy keeps the output a flop; one cycle latency
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      fifo_empty_reg <= 1'b1;
    else
      fifo_empty_reg <= i_fifo_count_zero;
  end

  msr_guard_timer u_guard (
    .i_clock       (i_clock),
    .i_rstn        (i_rstn),
    .i_uart_rstn   (i_uart_reset_release),
    .i_protocol_t1 (i_protocol_t1),
    .i_etu_tick    (i_etu_tick),
    .i_start_bit   (i_io_start_bit),
    .o_guard_done  (guard_done)
  );

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      tx_mode_reg <= 1'b0;
    else
      tx_mode_reg <= i_evt.tx_mode;
  end

  assign mode_to_tx     = i_evt.tx_mode && !tx_mode_reg;
  assign mode_to_rx     = !i_evt.tx_mode && tx_mode_reg;
  assign holding_access = (i_bus.addr == msr_pkg::TX_RX_HOLDING_ADDR) && (i_bus.wr || i_bus.rd);

  // Holding access clear lands three cycles after the access
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn || !i_uart_reset_release)
    begin
      clear_delay_reg   <= 2'h0;
      clear_pending_reg <= 1'b0;
    end
    else if (holding_access)
    begin
      clear_delay_reg   <= msr_pkg::FLAG_CLEAR_DELAY - 2'h1;
      clear_pending_reg <= 1'b1;
    end
    else if (clear_pending_reg)
    begin
      if (clear_delay_reg == 2'h0)
        clear_pending_reg <= 1'b0;
      else
        clear_delay_reg <= clear_delay_reg - 2'h1;
    end
  end

  assign set_event = mode_to_tx
                   || (i_evt.tx_char_done && !(i_evt.last_char_tx_mode && !i_evt.tx_parity_error))
                   || (!i_evt.tx_mode && i_evt.rx_buffer_full);
  assign clear_event = mode_to_rx
                     || (clear_pending_reg && clear_delay_reg == 2'h0);

  // Set wins over a simultaneous clear so no event is lost
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn || !i_uart_reset_release)
      tx_empty_rx_full_reg <= msr_pkg::TX_EMPTY_RX_FULL_RESET;
    else if (set_event)
      tx_empty_rx_full_reg <= 1'b1;
    else if (clear_event)
      tx_empty_rx_full_reg <= 1'b0;
  end

  always_comb
  begin
    status_next                                 = 8'h00;
    status_next[msr_pkg::CLOCK_SWITCH_DONE_BIT] = clock_switch_done_reg;
    status_next[msr_pkg::FIFO_EMPTY_FLAG_BIT]   = fifo_empty_reg;
    status_next[msr_pkg::BLOCK_GUARD_FLAG_BIT]  = guard_done;
    status_next[msr_pkg::CARD_PRESENCE_BIT]     = presence_sync_reg;
    status_next[msr_pkg::TX_EMPTY_RX_FULL_BIT]  = tx_empty_rx_full_reg;
  end

  // Read-only view: bus writes and reads of the status address never touch the state
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      o_mixed_status <= 8'h40;
    else
      o_mixed_status <= status_next;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      o_host_irq_n <= 1'b1;
    else
      o_host_irq_n <= !(tx_empty_rx_full_reg && !i_tx_rx_flag_irq_mask);
  end

endmodule : msr_mixed_status

// file: verilog/msr_pkg.sv
// Package for the mixed status register block: offsets, bit positions, timing, carrier types
package msr_pkg;

  localparam logic [3:0] MIXED_STATUS_ADDR   = 4'h0c;
  localparam logic [3:0] TX_RX_HOLDING_ADDR  = 4'h0d;

  localparam int CLOCK_SWITCH_DONE_BIT = 7;
  localparam int FIFO_EMPTY_FLAG_BIT   = 6;
  localparam int BLOCK_GUARD_FLAG_BIT  = 5;
  localparam int CARD_PRESENCE_BIT     = 2;
  localparam int TX_EMPTY_RX_FULL_BIT  = 0;

  localparam logic CLOCK_SWITCH_DONE_RESET = 1'b0;
  localparam logic BLOCK_GUARD_FLAG_RESET  = 1'b0;
  localparam logic TX_EMPTY_RX_FULL_RESET  = 1'b0;

  localparam logic [4:0] GUARD_ETU_T1 = 5'h16;
  localparam logic [4:0] GUARD_ETU_T0 = 5'h10;

  localparam logic [1:0] FLAG_CLEAR_DELAY = 2'h3;

  typedef struct packed {
    logic [3:0] addr;
    logic       rd;
    logic       wr;
  } msr_bus_t;

  typedef struct packed {
    logic tx_char_done;
    logic tx_parity_error;
    logic last_char_tx_mode;
    logic rx_buffer_full;
    logic tx_mode;
  } msr_uart_evt_t;

endpackage : msr_pkg

// file: verilog/msr_guard_timer.sv
// Block guard time counter clocked by ETU ticks
`timescale 1ns/1ps
module msr_guard_timer (
  input  wire logic i_clock,
  input  wire logic i_rstn,
  input  wire logic i_uart_rstn,
  input  wire logic i_protocol_t1,
  input  wire logic i_etu_tick,
  input  wire logic i_start_bit,
  output logic      o_guard_done
);

  logic [4:0] count_reg;
  logic       running_reg;
  logic [4:0] limit;

  assign limit = i_protocol_t1 ? msr_pkg::GUARD_ETU_T1 : msr_pkg::GUARD_ETU_T0;

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn || !i_uart_rstn)
    begin
      count_reg    <= 5'h00;
      running_reg  <= 1'b0;
      o_guard_done <= msr_pkg::BLOCK_GUARD_FLAG_RESET;
    end
    else if (i_start_bit)
    begin
      // Restart drops the flag; card answered before guard expired
      count_reg    <= 5'h00;
      running_reg  <= 1'b1;
      o_guard_done <= 1'b0;
    end
    else if (running_reg && i_etu_tick)
    begin
      if (count_reg + 5'h01 >= limit)
      begin
        running_reg  <= 1'b0;
        o_guard_done <= 1'b1;
      end
      count_reg <= count_reg + 5'h01;
    end
  end

endmodule : msr_guard_timer

// file: tb/msr_monitor.sv
// Checker bound to the mixed status register ports
`timescale 1ns/1ps
module msr_monitor (
  input wire logic                   i_clock,
  input wire logic                   i_rstn,
  input wire logic                   i_uart_reset_release,
  input wire msr_pkg::msr_bus_t      i_bus,
  input wire msr_pkg::msr_uart_evt_t i_evt,
  input wire logic                   i_clk_switch_to_int_done,
  input wire logic                   i_fifo_count_zero,
  input wire logic                   i_protocol_t1,
  input wire logic                   i_etu_tick,
  input wire logic                   i_io_start_bit,
  input wire logic                   i_card_presence_pin,
  input wire logic                   i_tx_rx_flag_irq_mask,
  input wire logic [7:0]             o_mixed_status,
  input wire logic                   o_host_irq_n
);
  logic [4:0] etu_cnt;
  always_ff @(posedge i_clock)
    if (!i_rstn || !i_uart_reset_release || i_io_start_bit)
      etu_cnt <= 5'h00;
    else if (i_etu_tick && etu_cnt != 5'h1f)
      etu_cnt <= etu_cnt + 5'h01;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  a_switch_sets_done:
    assert property (i_clk_switch_to_int_done |-> ##2 o_mixed_status[7]) else $error("switch bit");
  a_fifo_empty_mirror:
    assert property ($stable(i_fifo_count_zero) [*3] |-> o_mixed_status[6] == i_fifo_count_zero)
      else $error("fifo bit");
  a_guard_count_end:
    assert property (o_mixed_status[5] == ($past(etu_cnt) >= ($past(i_protocol_t1) ? 22 : 16)))
      else $error("guard bit");
  a_presence_mirror:
    assert property ((i_rstn && $stable(i_card_presence_pin)) [*4] |-> o_mixed_status[2] == i_card_presence_pin)
      else $error("presence bit");
  a_char_sets_flag:
    assert property (i_evt.tx_char_done && (i_evt.tx_parity_error || !i_evt.last_char_tx_mode)
      |-> ##2 o_mixed_status[0]) else $error("char flag");
  a_mode_sets_flag:
    assert property ($rose(i_evt.tx_mode) |-> ##2 o_mixed_status[0]) else $error("mode flag");
  a_irq_follows_flag:
    assert property (o_host_irq_n == !(o_mixed_status[0] && !$past(i_tx_rx_flag_irq_mask)))
      else $error("irq line");
  a_holding_clears_flag:
    assert property ((i_bus.wr || i_bus.rd) && i_bus.addr == msr_pkg::TX_RX_HOLDING_ADDR && o_mixed_status[0]
      |-> ##1 o_mixed_status[0] [*4] ##1 !o_mixed_status[0]) else $error("clear delay");
endmodule : msr_monitor
bind msr_mixed_status msr_monitor mon_u (.*);

// file: tb/msr_host_model.sv
// Controller model issuing register accesses
`timescale 1ns/1ps
module msr_host_model (
  input  wire logic        i_clock,
  input  wire logic [7:0]  i_status,
  output msr_pkg::msr_bus_t o_bus
);
  initial o_bus = '0;
  task automatic acc(input logic [3:0] a, input logic r);
    @(negedge i_clock);
    o_bus = '{addr: a, rd: r, wr: !r};
    @(negedge i_clock);
    o_bus = '{addr: ~a, rd: 1'b0, wr: 1'b0};
  endtask : acc
  // Bounded wait so a stuck switch cannot hang the run
  task automatic wait_switch();
    repeat (20) if (i_status[msr_pkg::CLOCK_SWITCH_DONE_BIT] !== 1'b1) @(posedge i_clock);
  endtask : wait_switch
endmodule : msr_host_model

// file: tb/testbench.sv
// Self-checking bench for the mixed status register
`timescale 1ns/1ps
module testbench;
  logic                   i_clock = 1'b0, i_rstn = 1'b0, i_uart_reset_release = 1'b1;
  msr_pkg::msr_bus_t      i_bus;
  msr_pkg::msr_uart_evt_t i_evt = '0;
  logic                   i_clk_switch_to_int_done = 1'b0, i_clk_switch_to_xtal_done = 1'b0;
  logic                   i_fifo_count_zero = 1'b1, i_protocol_t1 = 1'b0, i_etu_tick = 1'b0;
  logic                   i_io_start_bit = 1'b0, i_card_presence_pin = 1'b1, i_tx_rx_flag_irq_mask = 1'b0;
  logic [7:0]             o_mixed_status;
  logic                   o_host_irq_n, rnd;
  logic                   take = 1'b0;
  logic [8:0]             exp_q[$];
  int                     bad_count = 0, n_checks = 0;
  msr_mixed_status dut_u (.*);
  msr_host_model host_u (.i_clock(i_clock), .i_status(o_mixed_status), .o_bus(i_bus));
  always #10 i_clock = ~i_clock;
  task automatic conclude();
    if (bad_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task automatic check(input logic [8:0] seen, input logic [8:0] want);
    n_checks++;
    if (seen !== want)
    begin
      bad_count++;
      $display("MISMATCH %0t got %h want %h", $time, seen, want);
    end
  endtask : check
  // Note the read at the edge, compare at the next low phase once outputs settled
  always @(posedge i_clock)
    take <= (i_bus.rd === 1'b1 && i_bus.addr === msr_pkg::MIXED_STATUS_ADDR);
  always @(negedge i_clock)
    if (take)
    begin
      check({o_host_irq_n, o_mixed_status}, exp_q.pop_front());
    end
  task automatic chk(input logic [8:0] e);
    repeat (4) @(negedge i_clock);
    exp_q.push_back(e);
    host_u.acc(msr_pkg::MIXED_STATUS_ADDR, 1'b1);
  endtask : chk
  task automatic pulse(ref logic s);
    @(negedge i_clock);
    s = 1'b1;
    @(negedge i_clock);
    s = 1'b0;
  endtask : pulse
  // Fields: done, parity error, last char mode, rx full, tx mode
  task automatic ev(input logic [4:0] v);
    @(negedge i_clock);
    i_evt = v;
    @(negedge i_clock);
    i_evt = v & 5'h0d;
  endtask : ev
  initial
  begin
    repeat (3000) @(posedge i_clock);
    bad_count++;
    conclude();
  end
  initial
  begin
    rnd = $urandom(32'hbb8e_f2c3);
    repeat (4) @(negedge i_clock);
    i_rstn = 1'b1;
    chk(9'h144);
    pulse(i_clk_switch_to_int_done);
    host_u.wait_switch();
    chk(9'h1c4);
    pulse(i_clk_switch_to_xtal_done);
    chk(9'h144);
    i_fifo_count_zero = 1'b0;
    chk(9'h104);
    i_fifo_count_zero = 1'b1;
    ev(5'h01);
    chk(9'h045);
    i_tx_rx_flag_irq_mask = 1'b1;
    host_u.acc(msr_pkg::MIXED_STATUS_ADDR, 1'b0);
    chk(9'h145);
    host_u.acc(msr_pkg::TX_RX_HOLDING_ADDR, 1'b0);
    chk(9'h144);
    ev(5'h15);
    chk(9'h144);
    ev(5'h19);
    chk(9'h145);
    host_u.acc(msr_pkg::TX_RX_HOLDING_ADDR, 1'b1);
    chk(9'h144);
    ev(5'h11);
    ev(5'h00);
    chk(9'h144);
    ev(5'h02);
    chk(9'h145);
    pulse(i_clk_switch_to_int_done);
    // UART reset held low across one full clock edge
    @(negedge i_clock);
    i_uart_reset_release = 1'b0;
    @(negedge i_clock);
    i_uart_reset_release = 1'b1;
    chk(9'h144);
    for (int p = 0; p < 2; p++)
    begin
      pulse(i_io_start_bit);
      i_protocol_t1 = p[0] ^ rnd;
      chk(9'h144);
      repeat (i_protocol_t1 ? 21 : 15) pulse(i_etu_tick);
      chk(9'h144);
      pulse(i_etu_tick);
      chk(9'h164);
    end
    i_card_presence_pin = 1'b0;
    chk(9'h160);
    conclude();
  end
endmodule : testbench
